// file: rtb_regs.svh
`ifndef RTB_REGS_SVH
`define RTB_REGS_SVH
// ==========================================
// Shared RAM map
`define RTB_STAGE_BASE 16'h0020
`define RTB_STAGE_LAST 5'h1F
`define RTB_LOG_BASE 16'h0040
`define RTB_HW_ADDR_WORD 16'h0000
// ==========================================
// Register offsets (byte addresses)
`define RTB_REG_CFG 8'h00
`define RTB_REG_IRQ_EN 8'h04
`define RTB_REG_LOG 8'h08
`define RTB_REG_STAT 8'h0C
`define RTB_CFG_STAGE_BIT 0
`define RTB_IRQ_EN_RST 16'h0000
`define RTB_CNT_MAX 8'hFF
// ==========================================
// Timing
`define RTB_CLK_NS 50
`define RTB_WORD_NS 20000
`define RTB_WORD_CYC (`RTB_WORD_NS / `RTB_CLK_NS)
`endif

// file: rtb_pkg.sv
package rtb_pkg;
  typedef enum logic [3:0] {
    RTB_IDLE, RTB_LEG_RD, RTB_LEG_WAIT, RTB_RX_WR, RTB_LOG_ID, RTB_LOG_AW,
    RTB_CP_RD, RTB_CP_WAIT, RTB_CP_WR
  } rtb_state_t;
endpackage

// file: rtb_legal.sv
`timescale 1ns/1ps
`include "rtb_regs.svh"
module rtb_legal
  import rtb_pkg::*;
(
  input wire logic ref_clk_i, // Clock
  input wire logic rst_n_i, // Async reset
  input wire logic ce_i, // Clock enable
  input wire logic fetch_i, // Legality word valid
  input wire logic [15:0] word_i, // Fetched legality word
  input wire logic [3:0] bit_i, // Low mode code bits
  output logic valid_o, // Verdict pulse
  output logic illegal_o // Fetched bit value
);
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      valid_o <= 1'b0;
      illegal_o <= 1'b0;
    end else if (ce_i) begin
      valid_o <= fetch_i;
      if (fetch_i) begin
        illegal_o <= word_i[bit_i]; // R05
      end
    end
  end

  a_verdict_bit: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && fetch_i |=> illegal_o == $past(word_i[bit_i])) // R05
    else $error("legality bit not taken from word");
endmodule // rtb_legal

// file: rtb_log.sv
`timescale 1ns/1ps
`include "rtb_regs.svh"
module rtb_log
  import rtb_pkg::*;
(
  input wire logic ref_clk_i, // Clock
  input wire logic rst_n_i, // Async reset
  input wire logic ce_i, // Clock enable
  input wire logic adv_i, // One log word stored
  input wire logic entry_i, // One interrupt logged
  input wire logic rd_clr_i, // Log register read
  output logic [15:0] addr_o, // Next log word address
  output logic [7:0] count_o // Events since last read
);
  logic [4:0] ptr;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr <= 5'h00;
    end else if (ce_i && adv_i) begin
      ptr <= ptr + 5'h01; // R17
    end
  end

  // Event wins over the clear on read
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count_o <= 8'h00;
    end else if (ce_i) begin
      if (entry_i) begin
        count_o <= rd_clr_i ? 8'h01 : (count_o == `RTB_CNT_MAX ? count_o : count_o + 8'h01);
      end else if (rd_clr_i) begin
        count_o <= 8'h00;
      end
    end
  end

  assign addr_o = `RTB_LOG_BASE | {11'h000, ptr}; // R15

  a_log_wrap: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && adv_i && ptr == 5'h1F |=> addr_o == `RTB_LOG_BASE) // R17
    else $error("log pointer did not wrap to base");
endmodule // rtb_log

// file: rtb_top.sv
// Contract
// R01 - host sets transmit mode words FFF2/FE01
// R02 - host sets broadcast transmit words FFFF/FE05
// R03 - host sets receive mode words FFCD/FFFF
// R04 - host sets broadcast receive low words FFFF
// R05 - low word bit N is mode N
// R06 - illegal bit: status only, error set
// R07 - staging buffer 0x20-0x3F when enabled
// R08 - staged words burst-copied after clean end
// R09 - errored staged message is never copied
// R10 - without staging, write each word directly
// R11 - without staging, no rollback on error
// R12 - host never writes staging region
// R13 - interrupt only when its enable set
// R14 - log, registers, two outputs, two acks
// R15 - 32-word log ring at 0x40-0x5F
// R16 - two log words per interrupt
// R17 - ident then address, pointer wraps
// R18 - ident word holds only occurring bits
// R19 - ident bit positions per source
// R20 - address word: control word or zero
// R21 - one ident word, one message pulse
`timescale 1ns/1ps
`include "rtb_regs.svh"
module rtb_top
  import rtb_pkg::*;
(
  input wire logic ref_clk_i, // 20 MHz clock
  input wire logic rst_n_i, // Async reset
  input wire logic ce_i, // Clock enable
  input wire logic wb_cyc_i, // Wishbone cycle
  input wire logic wb_stb_i, // Wishbone strobe
  input wire logic wb_we_i, // Wishbone write
  input wire logic [7:0] wb_adr_i, // Byte address
  input wire logic [3:0] wb_sel_i, // Byte selects
  input wire logic [31:0] wb_dat_i, // Write data
  output logic [31:0] wb_dat_o, // Read data
  output logic wb_ack_o, // Acknowledge
  output logic [15:0] ram_addr_o, // Shared RAM address
  output logic [15:0] ram_wdata_o, // Shared RAM write data
  output logic ram_we_o, // Shared RAM write
  output logic ram_re_o, // Shared RAM read
  input wire logic [15:0] ram_rdata_i, // Data one cycle after read
  input wire logic leg_req_i, // Mode command legality check
  input wire logic [15:0] leg_pair_addr_i, // Even address of word pair
  input wire logic [4:0] leg_mc_i, // Mode code
  output logic resp_valid_o, // Response verdict pulse
  output logic resp_status_only_o, // Status word only
  output logic resp_msg_error_o, // Message error bit
  output logic status_update_o, // Terminal status update pulse
  input wire logic rx_start_i, // Receive message starts
  input wire logic [15:0] rx_dest_addr_i, // Subaddress buffer address
  input wire logic rx_word_valid_i, // Received data word
  input wire logic [15:0] rx_word_i, // Data word
  input wire logic msg_end_i, // Message complete
  input wire logic msg_err_i, // Message ended in error
  input wire logic [4:0] msg_evt_i, // Index0, access, bcast, error, illegal
  input wire logic [15:0] msg_ctrl_addr_i, // Descriptor control word address
  input wire logic [7:0] hw_evt_i, // Hardware interrupt events
  output logic msg_irq_out_o, // Message interrupt pin
  output logic hw_irq_out_o, // Hardware interrupt pin
  input wire logic msg_ack_i, // Message acknowledge pin
  input wire logic hw_ack_i // Hardware acknowledge pin
);
  localparam int WORD_CYC = `RTB_WORD_CYC;

  // ==========================================
  // Registers
  logic stage_en;
  logic [15:0] irq_en;
  logic [15:0] log_addr;
  logic [7:0] log_count;
  logic wb_req;
  logic log_rd;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign log_rd = wb_req && !wb_we_i && wb_adr_i == `RTB_REG_LOG;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
      stage_en <= 1'b0;
      irq_en <= `RTB_IRQ_EN_RST;
    end else if (ce_i) begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i) begin
        if (wb_adr_i == `RTB_REG_CFG && wb_sel_i[0]) begin
          stage_en <= wb_dat_i[`RTB_CFG_STAGE_BIT];
        end
        if (wb_adr_i == `RTB_REG_IRQ_EN) begin
          if (wb_sel_i[0]) irq_en[7:0] <= wb_dat_i[7:0];
          if (wb_sel_i[1]) irq_en[15:8] <= wb_dat_i[15:8];
        end
      end
      if (wb_req && !wb_we_i) begin
        unique case (wb_adr_i)
          `RTB_REG_CFG: wb_dat_o <= {31'h0000_0000, stage_en};
          `RTB_REG_IRQ_EN: wb_dat_o <= {16'h0000, irq_en};
          `RTB_REG_LOG: wb_dat_o <= {16'h0000, log_count, log_addr[7:0]};
          `RTB_REG_STAT: wb_dat_o <= {29'h0000_0000, msg_irq_out_o, hw_irq_out_o, resp_status_only_o};
          default: wb_dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ==========================================
  // Acknowledge pin synchronisers
  logic [1:0] msg_ack_sync;
  logic [1:0] hw_ack_sync;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      msg_ack_sync <= 2'b00;
      hw_ack_sync <= 2'b00;
    end else if (ce_i) begin
      msg_ack_sync <= {msg_ack_sync[0], msg_ack_i};
      hw_ack_sync <= {hw_ack_sync[0], hw_ack_i};
    end
  end

  // ==========================================
  // Pending requests
  rtb_state_t state;
  logic [15:0] msg_bits;
  logic [15:0] hw_bits;
  assign msg_bits = {msg_evt_i[4:2], 2'b00, msg_evt_i[1], 1'b0, msg_evt_i[0], 8'h00} & irq_en; // R13 R19
  assign hw_bits = {8'h00, hw_evt_i} & irq_en; // R13 R19

  logic rx_pend, leg_pend, cp_pend, msg_pend, hw_pend;
  logic [15:0] rx_data, rx_dest;
  logic [4:0] rx_idx, rx_cnt, cp_idx;
  logic [15:0] leg_addr;
  logic [3:0] leg_bit;
  logic [15:0] msg_id, msg_aw, hw_id, log_id, log_aw;
  logic log_is_msg, rx_any;
  logic take_rx, take_leg, take_cp, take_msg, take_hw;
  logic idle;
  assign idle = state == RTB_IDLE;
  assign take_rx = idle && rx_pend;
  assign take_leg = idle && !rx_pend && leg_pend;
  assign take_cp = idle && !rx_pend && !leg_pend && cp_pend;
  assign take_msg = idle && !rx_pend && !leg_pend && !cp_pend && msg_pend;
  assign take_hw = idle && !rx_pend && !leg_pend && !cp_pend && !msg_pend && hw_pend;

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rx_pend <= 1'b0;
      rx_data <= 16'h0000;
      rx_dest <= 16'h0000;
      rx_idx <= 5'h00;
      rx_cnt <= 5'h00;
      cp_pend <= 1'b0;
      rx_any <= 1'b0;
    end else if (ce_i) begin
      if (rx_start_i) begin
        rx_dest <= rx_dest_addr_i;
        rx_idx <= 5'h00;
        rx_any <= 1'b0;
      end
      if (rx_word_valid_i) begin
        rx_data <= rx_word_i;
        rx_pend <= 1'b1;
      end else if (take_rx) begin
        rx_pend <= 1'b0;
      end
      if (state == RTB_RX_WR) begin
        rx_idx <= rx_idx + 5'h01;
        rx_any <= 1'b1;
      end
      // Index wraps to zero after 32 words, so a flag marks any word seen
      if (msg_end_i && stage_en && !msg_err_i && rx_any) begin
        cp_pend <= 1'b1; // R08
        rx_cnt <= rx_idx - 5'h01;
      end else if (take_cp) begin
        cp_pend <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      leg_pend <= 1'b0;
      leg_addr <= 16'h0000;
      leg_bit <= 4'h0;
    end else if (ce_i) begin
      if (leg_req_i) begin
        leg_pend <= 1'b1;
        leg_addr <= leg_pair_addr_i | {15'h0000, leg_mc_i[4]}; // R05
        leg_bit <= leg_mc_i[3:0];
      end else if (take_leg) begin
        leg_pend <= 1'b0;
      end
    end
  end

  // New events merge into a waiting entry; set wins over the take
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      msg_pend <= 1'b0;
      hw_pend <= 1'b0;
      msg_id <= 16'h0000;
      msg_aw <= 16'h0000;
      hw_id <= 16'h0000;
    end else if (ce_i) begin
      if (msg_bits != 16'h0000) begin
        msg_pend <= 1'b1;
        msg_id <= (take_msg ? 16'h0000 : msg_id) | msg_bits; // R21
        msg_aw <= msg_ctrl_addr_i; // R20
      end else if (take_msg) begin
        msg_pend <= 1'b0;
        msg_id <= 16'h0000;
      end
      if (hw_bits != 16'h0000) begin
        hw_pend <= 1'b1;
        hw_id <= (take_hw ? 16'h0000 : hw_id) | hw_bits;
      end else if (take_hw) begin
        hw_pend <= 1'b0;
        hw_id <= 16'h0000;
      end
    end
  end

  // ==========================================
  // Shared RAM sequencer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= RTB_IDLE;
      ram_addr_o <= 16'h0000;
      ram_wdata_o <= 16'h0000;
      ram_we_o <= 1'b0;
      ram_re_o <= 1'b0;
      cp_idx <= 5'h00;
      log_id <= 16'h0000;
      log_aw <= 16'h0000;
      log_is_msg <= 1'b0;
    end else if (ce_i) begin
      ram_we_o <= 1'b0;
      ram_re_o <= 1'b0;
      unique case (state)
        RTB_IDLE: begin
          if (take_rx) begin
            state <= RTB_RX_WR;
            ram_we_o <= 1'b1;
            ram_wdata_o <= rx_data;
            ram_addr_o <= stage_en ? (`RTB_STAGE_BASE | {11'h000, rx_idx}) // R07
                                   : rx_dest + {11'h000, rx_idx}; // R10 R11
          end else if (take_leg) begin
            state <= RTB_LEG_RD;
            ram_re_o <= 1'b1;
            ram_addr_o <= leg_addr;
          end else if (take_cp) begin
            state <= RTB_CP_RD;
            cp_idx <= 5'h00;
            ram_re_o <= 1'b1;
            ram_addr_o <= `RTB_STAGE_BASE;
          end else if (take_msg || take_hw) begin
            state <= RTB_LOG_ID;
            log_is_msg <= take_msg;
            log_id <= take_msg ? msg_id : hw_id; // R18
            log_aw <= take_msg ? msg_aw : `RTB_HW_ADDR_WORD; // R20
            ram_we_o <= 1'b1;
            ram_addr_o <= log_addr;
            ram_wdata_o <= take_msg ? msg_id : hw_id; // R16 R17
          end
        end
        RTB_RX_WR: state <= RTB_IDLE;
        RTB_LEG_RD: state <= RTB_LEG_WAIT;
        RTB_LEG_WAIT: state <= RTB_IDLE;
        RTB_LOG_ID: begin
          state <= RTB_LOG_AW;
          ram_we_o <= 1'b1;
          ram_addr_o <= ram_addr_o + 16'h0001;
          ram_wdata_o <= log_aw; // R16 R17
        end
        RTB_LOG_AW: state <= RTB_IDLE;
        RTB_CP_RD: state <= RTB_CP_WAIT;
        RTB_CP_WAIT: begin
          state <= RTB_CP_WR;
          ram_we_o <= 1'b1;
          ram_wdata_o <= ram_rdata_i;
          ram_addr_o <= rx_dest + {11'h000, cp_idx}; // R08
        end
        RTB_CP_WR: begin
          if (cp_idx == rx_cnt) begin
            state <= RTB_IDLE;
          end else begin
            state <= RTB_CP_RD;
            cp_idx <= cp_idx + 5'h01;
            ram_re_o <= 1'b1;
            ram_addr_o <= `RTB_STAGE_BASE | {11'h000, cp_idx + 5'h01};
          end
        end
      endcase
    end
  end

  // ==========================================
  // Legality verdict and log pointer
  logic leg_valid, leg_illegal;
  rtb_legal u_legal (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .fetch_i(state == RTB_LEG_WAIT),
    .word_i(ram_rdata_i),
    .bit_i(leg_bit),
    .valid_o(leg_valid),
    .illegal_o(leg_illegal)
  );

  rtb_log u_log (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .ce_i(ce_i),
    .adv_i(state == RTB_LOG_ID || state == RTB_LOG_AW),
    .entry_i(state == RTB_LOG_AW),
    .rd_clr_i(log_rd),
    .addr_o(log_addr),
    .count_o(log_count)
  );

  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_status_only_o <= 1'b0;
      resp_msg_error_o <= 1'b0;
      status_update_o <= 1'b0;
    end else if (ce_i) begin
      resp_valid_o <= leg_valid;
      status_update_o <= leg_valid; // R06
      if (leg_valid) begin
        resp_status_only_o <= leg_illegal; // R06
        resp_msg_error_o <= leg_illegal; // R06
      end
    end
  end

  // ==========================================
  // Interrupt pins, raise wins over acknowledge
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      msg_irq_out_o <= 1'b0;
      hw_irq_out_o <= 1'b0;
    end else if (ce_i) begin
      if (state == RTB_LOG_AW && log_is_msg) begin
        msg_irq_out_o <= 1'b1; // R14 R21
      end else if (msg_ack_sync[1]) begin
        msg_irq_out_o <= 1'b0; // R14
      end
      if (state == RTB_LOG_AW && !log_is_msg) begin
        hw_irq_out_o <= 1'b1; // R14
      end else if (hw_ack_sync[1]) begin
        hw_irq_out_o <= 1'b0; // R14
      end
    end
  end

  // ==========================================
  // Checks
  a_illegal_resp: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    resp_valid_o |-> resp_status_only_o == resp_msg_error_o && status_update_o) // R06
    else $error("illegal response fields disagree");
  a_stage_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && take_rx && stage_en |=> ram_we_o && ram_addr_o[15:5] == 11'h001) // R07
    else $error("staged word outside staging buffer");
  a_direct_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && take_rx && !stage_en |=> ram_we_o && ram_addr_o == $past(rx_dest + {11'h000, rx_idx})) // R10
    else $error("direct word not at subaddress buffer");
  a_word_served: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && rx_word_valid_i |-> ##[1:WORD_CYC] ram_we_o) // R10
    else $error("received word not written in time");
  a_no_err_copy: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && msg_end_i && msg_err_i && !cp_pend |=> !cp_pend) // R09
    else $error("errored message scheduled for copy");
  a_irq_enable: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state == RTB_LOG_ID |-> (log_id & ~irq_en) == 16'h0000 || $changed(irq_en)) // R13
    else $error("disabled interrupt logged");
  a_log_pair: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && state == RTB_LOG_ID |-> ram_we_o && ram_wdata_o == log_id
      ##1 ram_we_o && ram_wdata_o == log_aw && ram_addr_o == $past(ram_addr_o) + 16'h0001) // R16 R17
    else $error("log pair not written in order");
  a_hw_zero_addr: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state == RTB_LOG_ID && !log_is_msg |-> log_aw == `RTB_HW_ADDR_WORD) // R20
    else $error("hardware entry address word not zero");
  a_log_in_ring: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state == RTB_LOG_ID |-> ram_addr_o[15:5] == 11'h002) // R15
    else $error("log write outside ring");
  a_one_msg_pin: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    ce_i && $rose(msg_irq_out_o) |-> $past(state) == RTB_LOG_AW && $past(log_is_msg)) // R21
    else $error("message pin raised without logged entry");

  c_illegal: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) resp_valid_o && resp_msg_error_o);
  c_copy: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) state == RTB_CP_WR && cp_idx == rx_cnt);
  c_wrap: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i) state == RTB_LOG_AW && log_addr[4:0] == 5'h1F);
  c_multi: cover property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    state == RTB_LOG_ID && log_id[10] && log_id[13]);
endmodule // rtb_top

// file: rtb_ram_model.sv
`timescale 1ns/1ps
// ==========
// Shared RAM, registered read
module rtb_ram_model (
  input wire logic ref_clk_i, // Clock
  input wire logic [15:0] addr_i, // Word address
  input wire logic [15:0] wdata_i, // Write data
  input wire logic we_i, // Write strobe
  input wire logic re_i, // Read strobe
  output logic [15:0] rdata_o // Read data
);
  logic [15:0] mem [0:1023];
  initial begin
    for (int i = 0; i < 1024; i++) begin
      mem[i] = 16'h0000;
    end
    rdata_o = 16'h0000;
  end
  // Data only valid the cycle after a read
  always @(posedge ref_clk_i) begin
    if (we_i) begin
      mem[addr_i[9:0]] <= wdata_i;
    end
    rdata_o <= re_i ? mem[addr_i[9:0]] : ~rdata_o;
  end
endmodule // rtb_ram_model

// file: tb.sv
`timescale 1ns/1ps
`include "rtb_regs.svh"
module tb;
  logic ref_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack, ram_we, ram_re;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, q;
  logic [15:0] ram_addr, ram_wdata, ram_rdata, p = 16'h0040;
  logic leg_req = 1'b0, resp_valid, st_only, msg_error, st_upd;
  logic [15:0] leg_pair = 16'h0, rx_dest = 16'h0, rx_word = 16'h0, ctrl = 16'h0;
  logic [4:0] leg_mc = 5'h0, mevt = 5'h0;
  logic rx_start = 1'b0, rx_valid = 1'b0, msg_end = 1'b0, msg_err = 1'b0;
  logic [7:0] hevt = 8'h00;
  logic msg_pin, hw_pin, pin_d = 1'b0, msg_ack = 1'b0, hw_ack = 1'b0;
  int n_fail = 0, comparisons = 0, rises = 0, cnt = 0;
  logic [15:0] pair [4] = '{16'h01C0, 16'h0140, 16'h0180, 16'h0100};
  logic [15:0] lo [4] = '{16'hFE01, 16'hFE05, 16'hFFFF, 16'hFFFF};
  logic [15:0] hi [4] = '{16'hFFF2, 16'hFFFF, 16'hFFCD, 16'hFFCD};

  rtb_top i_rtb_top (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .ram_addr_o(ram_addr),
    .ram_wdata_o(ram_wdata), .ram_we_o(ram_we), .ram_re_o(ram_re), .ram_rdata_i(ram_rdata),
    .leg_req_i(leg_req), .leg_pair_addr_i(leg_pair), .leg_mc_i(leg_mc),
    .resp_valid_o(resp_valid), .resp_status_only_o(st_only), .resp_msg_error_o(msg_error),
    .status_update_o(st_upd), .rx_start_i(rx_start), .rx_dest_addr_i(rx_dest),
    .rx_word_valid_i(rx_valid), .rx_word_i(rx_word), .msg_end_i(msg_end), .msg_err_i(msg_err),
    .msg_evt_i(mevt), .msg_ctrl_addr_i(ctrl), .hw_evt_i(hevt), .msg_irq_out_o(msg_pin),
    .hw_irq_out_o(hw_pin), .msg_ack_i(msg_ack), .hw_ack_i(hw_ack));
  rtb_ram_model i_rtb_ram_model (.ref_clk_i(ref_clk_i), .addr_i(ram_addr),
    .wdata_i(ram_wdata), .we_i(ram_we), .re_i(ram_re), .rdata_o(ram_rdata));

  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  always @(posedge ref_clk_i) begin
    pin_d <= msg_pin;
    if (msg_pin && !pin_d) rises <= rises + 1;
  end

  // ==========
  // Helpers
  task tick(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask
  task end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge ref_clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge ref_clk_i);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (ack !== 1'b1) chk("wb_ack_o", 32'h1, 32'h0);
  endtask
  task leg(input int k, input logic [4:0] mc);
    logic [31:0] e;
    int n;
    e = {31'h0, mc[4] ? hi[k][mc[3:0]] : lo[k][mc[3:0]]};
    n = 0;
    @(posedge ref_clk_i);
    leg_req <= 1'b1;
    leg_pair <= pair[k];
    leg_mc <= mc;
    @(posedge ref_clk_i);
    leg_req <= 1'b0;
    while (resp_valid !== 1'b1 && n < 300) begin
      @(posedge ref_clk_i);
      n++;
    end
    chk("status_update_o", 32'h1, {31'h0, st_upd});
    chk("resp_status_only_o", e, {31'h0, st_only});
    chk("resp_msg_error_o", e, {31'h0, msg_error});
  endtask
  task rx(input logic [15:0] d, input int n, input logic er, input logic st);
    logic [15:0] w [32];
    logic [15:0] old [32];
    for (int i = 0; i < n; i++) begin
      old[i] = i_rtb_ram_model.mem[d + i];
      w[i] = 16'($urandom);
    end
    @(posedge ref_clk_i);
    rx_start <= 1'b1;
    rx_dest <= d;
    tick(1);
    rx_start <= 1'b0;
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_word <= w[i];
      tick(1);
      rx_valid <= 1'b0;
      tick(9);
    end
    msg_end <= 1'b1;
    msg_err <= er;
    tick(1);
    msg_end <= 1'b0;
    tick(4 * n + 20);
    // Staging area only read back, never written
    for (int i = 0; i < n; i++) begin
      if (st) chk("stage", w[i], i_rtb_ram_model.mem[`RTB_STAGE_BASE + i]);
      chk("dest", (st && er) ? old[i] : w[i], i_rtb_ram_model.mem[d + i]);
    end
  endtask
  task irq(input logic [4:0] m, input logic [7:0] h, input logic [15:0] en);
    logic [15:0] id;
    logic [15:0] c;
    int r;
    id = {m[4], m[3], m[2], 2'b00, m[1], 1'b0, m[0], h} & en;
    c = 16'($urandom_range(16'h0200, 16'h03FF));
    r = rises;
    @(posedge ref_clk_i);
    mevt <= m;
    hevt <= h;
    ctrl <= c;
    tick(1);
    mevt <= 5'h0;
    hevt <= 8'h00;
    tick(8);
    if (id != 16'h0) begin
      chk("ident", id, i_rtb_ram_model.mem[p]);
      chk("addr", (id[15:8] != 0) ? c : `RTB_HW_ADDR_WORD, i_rtb_ram_model.mem[p + 1]);
      p = (p == 16'h005E) ? `RTB_LOG_BASE : p + 16'h2;
      cnt++;
    end
    chk("msg_pin", id[15:8] != 0, msg_pin);
    chk("hw_pin", id[7:0] != 0, hw_pin);
    chk("rises", 32'(r + (id[15:8] != 0)), 32'(rises));
    msg_ack <= 1'b1;
    hw_ack <= 1'b1;
    tick(5);
    chk("pins_acked", 32'h0, {30'h0, msg_pin, hw_pin});
    msg_ack <= 1'b0;
    hw_ack <= 1'b0;
    tick(3);
  endtask

  // ==========
  // Main sequence
  initial begin
    void'($urandom(32'h118223EF));
    tick(6);
    rst_n_i <= 1'b1;
    wb(1'b0, `RTB_REG_LOG, 32'h0);
    chk("log_reset", 32'h0000_0040, q);
    wb(1'b0, `RTB_REG_IRQ_EN, 32'h0);
    chk("irq_en_reset", 32'h0, q);
    wb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 32'h0, q);
    for (int k = 0; k < 4; k++) begin
      i_rtb_ram_model.mem[pair[k]] = lo[k];
      i_rtb_ram_model.mem[pair[k] + 1] = hi[k];
      leg(k, 5'h00);
      leg(k, 5'h1F);
      repeat (6) leg(k, 5'($urandom));
    end
    leg(0, 5'h00);
    wb(1'b0, `RTB_REG_STAT, 32'h0);
    chk("stat", 32'h1, q);
    wb(1'b1, `RTB_REG_CFG, 32'h0);
    rx(16'h0200, 5, 1'b0, 1'b0);
    rx(16'h0200, 3, 1'b1, 1'b0);
    wb(1'b1, `RTB_REG_CFG, 32'h1);
    wb(1'b0, `RTB_REG_CFG, 32'h0);
    chk("cfg", 32'h1, q);
    rx(16'h0240, 32, 1'b0, 1'b1);
    rx(16'h0240, 4, 1'b1, 1'b1);
    rx(16'h0280, $urandom_range(1, 31), 1'b0, 1'b1);
    wb(1'b1, `RTB_REG_IRQ_EN, 32'hFFFF);
    irq(5'b00110, 8'h00, 16'hFFFF);
    for (int i = 0; i < 18; i++) begin
      if (i % 2) irq(5'h0, 8'($urandom_range(1, 255)), 16'hFFFF);
      else irq(5'($urandom_range(1, 31)), 8'h00, 16'hFFFF);
    end
    wb(1'b0, `RTB_REG_LOG, 32'h0);
    chk("log_wrapped", {16'h0, cnt[7:0], p[7:0]}, q);
    cnt = 0;
    wb(1'b0, `RTB_REG_LOG, 32'h0);
    chk("log_cleared", {24'h0, p[7:0]}, q);
    wb(1'b1, `RTB_REG_IRQ_EN, 32'hFBF7);
    irq(5'b00010, 8'h00, 16'hFBF7);
    irq(5'h0, 8'h08, 16'hFBF7);
    irq(5'b00011, 8'h00, 16'hFBF7);
    wb(1'b0, `RTB_REG_LOG, 32'h0);
    chk("log_masked", {16'h0, cnt[7:0], p[7:0]}, q);
    end_of_test();
  end
  initial begin
    #(50 * 20000);
    n_fail++;
    end_of_test();
  end
endmodule // tb
